// ==== lfs_config_port.sv ====
// serial configuration and command port of the low-frequency front end
`timescale 1ns/1ps
`include "lfs_params.svh"

module lfs_config_port #(
	parameter int SW = 8
) (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              serial_clk,
	input  wire logic              cs_n,
	input  wire logic              sdio_in,
	output logic                   sdio_out,
	output logic                   sdio_oe_n,
	output logic                   alert_out,
	output logic                   alert_oe_n,
	input  wire logic              demod_in,
	input  wire logic              carrier_in,
	input  wire logic              activity_in,
	input  wire logic              alarm_in,
	input  wire logic              agc_active_in,
	input  wire logic [2:0]        wake_chan_in,
	input  wire logic [2:0]        active_chan_in,
	input  wire logic [SW-1:0]     strength_x,
	input  wire logic [SW-1:0]     strength_y,
	input  wire logic [SW-1:0]     strength_z,
	output lfs_pkg::lfs_mode_type  frontend_mode,
	output logic                   clamp_on,
	output logic                   agc_preserve,
	output logic                   soft_reset_pulse,
	output logic                   timers_enable,
	output logic                   rssi_enable,
	output logic [1:0]             rssi_channel,
	output logic                   rssi_valid,
	output logic                   discharge_pulldown_enable
);

	lfs_pkg::lfs_link_type lk_q;
	lfs_pkg::lfs_link_type lk_d;
	lfs_pkg::lfs_core_type q;
	lfs_pkg::lfs_core_type d;

	logic                  mem_we;
	logic [3:0]            mem_waddr;
	logic [`LFS_REG_W-1:0] mem_wdata;
	logic [3:0]            mem_raddr;
	logic [`LFS_REG_W-1:0] mem_rdata;

	if (SW < 1) begin : g_check
		$error("lfs_config_port: SW must be at least 1");
	end

	// true when a nine-bit word holds an odd number of ones
	function automatic logic odd_ok(input logic [`LFS_REG_W-1:0] v);
		return ^v;
	endfunction : odd_ok

	// strongest enabled channel as {valid, channel}; a set disable bit drops it
	function automatic logic [2:0] strongest(
		input logic [2:0]    dis,
		input logic [SW-1:0] x,
		input logic [SW-1:0] y,
		input logic [SW-1:0] z
	);
		logic [SW-1:0] best;
		logic [2:0]    res;
		best = '0;
		res  = 3'h0;
		if (!dis[0]) begin
			best = x;
			res  = 3'h4;
		end
		if (!dis[1] && (!res[2] || y > best)) begin
			best = y;
			res  = 3'h5;
		end
		if (!dis[2] && (!res[2] || z > best)) begin
			res  = 3'h6;
		end
		return res;
	endfunction : strongest

	lfs_regfile #(
		.DEPTH (`LFS_REG_DEPTH),
		.W     (`LFS_REG_W)
	) u_regs (
		.clk     (clk),
		.reset_n (reset_n),
		.wr_en   (mem_we),
		.wr_addr (mem_waddr),
		.wr_data (mem_wdata),
		.rd_addr (mem_raddr),
		.rd_data (mem_rdata)
	);

	// link side: shift in on the rising edge while selected, count those edges modulo 256
	always_comb begin
		lk_d       = lk_q;
		if (!cs_n) begin
			lk_d.shift = {lk_q.shift[14:0], sdio_in};
			lk_d.cnt   = 8'(lk_q.cnt + 8'h01);
		end
	end

	// the pulled-up clock pin also moves between frames, so only selected edges count
	always_ff @(posedge serial_clk or negedge reset_n) begin
		if (!reset_n) begin
			lk_q <= '0;
		end else begin
			lk_q <= lk_d;
		end
	end

	// core side: frame decode, register access, mode and pin control
	always_comb begin
		logic                  cs_rise;
		logic                  sck_fall;
		logic [7:0]            edges;
		logic                  frame_ok;
		logic [2:0]            cmd;
		logic [3:0]            adr;
		logic [`LFS_REG_W-1:0] dat;
		logic                  rssi_mode;
		logic                  wrote;
		logic [2:0]            best;
		logic [`LFS_REG_W-1:0] status;
		logic [`LFS_REG_W-1:0] cur;
		cs_rise   = 1'b0;
		sck_fall  = 1'b0;
		edges     = 8'h00;
		frame_ok  = 1'b0;
		cmd       = 3'h0;
		adr       = 4'h0;
		dat       = '0;
		rssi_mode = 1'b0;
		wrote     = 1'b0;
		best      = 3'h0;
		status    = '0;
		cur       = '0;
		d         = q;
		mem_we    = 1'b0;
		mem_waddr = 4'h0;
		mem_wdata = '0;
		mem_raddr = {1'b0, q.scan_idx};

		// pin inputs pass two flip-flops
		d.cs_m  = cs_n;
		d.cs_s  = q.cs_m;
		d.cs_d  = q.cs_s;
		d.sck_m = serial_clk;
		d.sck_s = q.sck_m;
		d.sck_d = q.sck_s;
		cs_rise  = q.cs_s & ~q.cs_d;
		sck_fall = q.sck_d & ~q.sck_s;

		// link state is still once select is high, so it is read here directly
		edges    = 8'(lk_q.cnt - q.cnt_start);
		frame_ok = (edges != 8'h00) && (edges[3:0] == 4'h0);
		cmd      = lk_q.shift[`LFS_CMD_HI:`LFS_CMD_LO];
		adr      = lk_q.shift[`LFS_ADR_HI:`LFS_ADR_LO];
		dat      = lk_q.shift[`LFS_REG_W-1:0];

		d.soft_rst = 1'b0;
		rssi_mode  = q.outsel[1];

		// falling edges inside a frame index the read response
		if (q.cs_s) begin
			d.fall_cnt = 5'h00;
		end else if (sck_fall && !q.fall_cnt[4]) begin
			d.fall_cnt = 5'(q.fall_cnt + 5'h01);
		end

		// mode follows the front end unless asleep; signal strength pins Active
		if (q.mode != lfs_pkg::mode_sleep) begin
			if (rssi_mode || activity_in) begin
				d.mode = lfs_pkg::mode_active;
			end else begin
				d.mode = lfs_pkg::mode_standby;
			end
		end

		// end of a frame: execute only whole frames, never the response frame
		if (cs_rise) begin
			d.cnt_start = lk_q.cnt;
			if (q.rd_armed) begin
				d.rd_armed = 1'b0;
			end else if (frame_ok) begin
				if (q.mode == lfs_pkg::mode_sleep && cmd != `LFS_CMD_SLEEP) begin
					d.mode = lfs_pkg::mode_standby;
				end
				case (cmd)
					`LFS_CMD_CLAMP_ON: begin
						d.clamp = 1'b1;
					end
					`LFS_CMD_CLAMP_OFF: begin
						d.clamp = 1'b0;
					end
					`LFS_CMD_SLEEP: begin
						d.mode = lfs_pkg::mode_sleep;
					end
					`LFS_CMD_AGC_ON: begin
						d.agc_pres = 1'b1;
					end
					`LFS_CMD_AGC_OFF: begin
						d.agc_pres = 1'b0;
					end
					`LFS_CMD_SOFT_RST: begin
						// clamp is left as it is across the soft reset
						d.soft_rst = (q.mode == lfs_pkg::mode_active);
					end
					`LFS_CMD_READ: begin
						d.fetch      = lfs_pkg::fetch_wait;
						d.fetch_addr = adr;
						mem_raddr    = adr;
						d.scan_idx   = 3'h0;
						d.row_err    = 1'b0;
						d.col_acc    = 8'h00;
					end
					`LFS_CMD_WRITE: begin
						// status and unmapped addresses take no write
						if (adr < `LFS_ADDR_STATUS) begin
							mem_we    = 1'b1;
							mem_waddr = adr;
							mem_wdata = dat;
							wrote     = 1'b1;
						end
						if (adr == `LFS_ADDR_GENERAL) begin
							d.chan_dis  = dat[`LFS_CHAN_DIS_HI:`LFS_CHAN_DIS_LO];
							d.alarm_ind = dat[`LFS_ALARM_IND_BIT];
						end
						if (adr == `LFS_ADDR_XTUNE) begin
							d.outsel = dat[`LFS_OUTSEL_HI:`LFS_OUTSEL_LO];
						end
						if (adr == `LFS_ADDR_YTUNE) begin
							d.pulldown_bit = dat[`LFS_PULLDOWN_BIT];
						end
					end
					default: begin
						d.clamp = q.clamp;
					end
				endcase
			end
		end

		// registered read data arrives one cycle after the fetch
		status = {active_chan_in, agc_active_in, wake_chan_in, alarm_in, q.parity_err};
		if (q.fetch == lfs_pkg::fetch_wait) begin
			d.fetch = lfs_pkg::fetch_idle;
			if (q.fetch_addr == `LFS_ADDR_STATUS) begin
				cur = status;
			end else begin
				cur = mem_rdata;
			end
			d.resp     = {{`LFS_DUMMY_BITS{1'b0}}, cur};
			d.rd_armed = 1'b1;
		end

		// background parity scan over words 0..6; a write or read restarts it
		if (wrote) begin
			d.scan_idx = 3'h0;
			d.row_err  = 1'b0;
			d.col_acc  = 8'h00;
		end else if (!(cs_rise && !q.rd_armed && frame_ok && cmd == `LFS_CMD_READ)) begin
			if (q.scan_idx != 3'h0) begin
				d.row_err = q.row_err | ~odd_ok(mem_rdata);
				d.col_acc = q.col_acc ^ mem_rdata[8:1];
			end
			if (q.scan_idx == 3'(`LFS_REG_DEPTH)) begin
				// each column, parity byte included, must hold an odd count
				d.parity_err = d.row_err | (d.col_acc != 8'hFF);
				d.scan_idx   = 3'h0;
				d.row_err    = 1'b0;
				d.col_acc    = 8'h00;
			end else begin
				d.scan_idx = 3'(q.scan_idx + 3'h1);
			end
		end

		// signal-strength side effects
		best          = strongest(q.chan_dis, strength_x, strength_y, strength_z);
		d.timers_en   = ~rssi_mode;
		d.rssi_en     = rssi_mode & q.cs_s & best[2];
		d.rssi_valid  = rssi_mode & best[2];
		d.rssi_ch     = best[1:0];
		d.pulldown_en = rssi_mode & q.pulldown_bit;

		// clock pin: open-collector fault pull-down only while select is high
		d.alert_out  = 1'b0;
		d.alert_oe_n = ~(q.cs_s & (q.parity_err | (q.alarm_ind & alarm_in)));

		// data pin: wake data when idle, read response inside the second frame
		if (q.cs_s) begin
			d.sdio_oe_n = rssi_mode;
			case (q.outsel)
				`LFS_OUT_DEMOD: begin
					d.sdio_out = demod_in;
				end
				`LFS_OUT_CARRIER: begin
					d.sdio_out = carrier_in;
				end
				default: begin
					d.sdio_out = 1'b0; // analog current owns the pad here
				end
			endcase
		end else if (q.rd_armed) begin
			// bit k follows the k-th falling edge; the gap supplies the first
			d.sdio_oe_n = 1'b0;
			if (q.fall_cnt[4]) begin
				d.sdio_out = 1'b0;
			end else begin
				d.sdio_out = q.resp[4'hF - q.fall_cnt[3:0]];
			end
		end else begin
			d.sdio_oe_n = 1'b1;
			d.sdio_out  = 1'b0;
		end
	end

	// core registers; reset leaves the port idle with the fault pulled low
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q            <= '0;
			q.cs_m       <= 1'b1;
			q.cs_s       <= 1'b1;
			q.cs_d       <= 1'b1;
			q.parity_err <= 1'b1;
			q.sdio_oe_n  <= 1'b1;
			q.alert_oe_n <= 1'b0;
			q.timers_en  <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign sdio_out                  = q.sdio_out;
	assign sdio_oe_n                 = q.sdio_oe_n;
	assign alert_out                 = q.alert_out;
	assign alert_oe_n                = q.alert_oe_n;
	assign frontend_mode             = q.mode;
	assign clamp_on                  = q.clamp;
	assign agc_preserve              = q.agc_pres;
	assign soft_reset_pulse          = q.soft_rst;
	assign timers_enable             = q.timers_en;
	assign rssi_enable               = q.rssi_en;
	assign rssi_channel              = q.rssi_ch;
	assign rssi_valid                = q.rssi_valid;
	assign discharge_pulldown_enable = q.pulldown_en;

endmodule : lfs_config_port

// ==== lfs_params.svh ====
// constants of the low-frequency front-end serial configuration port
`ifndef LFS_PARAMS_SVH
`define LFS_PARAMS_SVH

// register addresses
`define LFS_ADDR_GENERAL   4'h0
`define LFS_ADDR_XTUNE     4'h1
`define LFS_ADDR_YTUNE     4'h2
`define LFS_ADDR_ZTUNE     4'h3
`define LFS_ADDR_XYSENS    4'h4
`define LFS_ADDR_ZSENS     4'h5
`define LFS_ADDR_COLPAR    4'h6
`define LFS_ADDR_STATUS    4'h7

// register geometry and reset value
`define LFS_REG_W          9
`define LFS_REG_DEPTH      7
`define LFS_REG_RESET      9'h000

// field positions
`define LFS_OUTSEL_HI      8
`define LFS_OUTSEL_LO      7
`define LFS_PULLDOWN_BIT   8
`define LFS_ALARM_IND_BIT  4
`define LFS_CHAN_DIS_HI    3
`define LFS_CHAN_DIS_LO    1

// output select codes
`define LFS_OUT_DEMOD      2'h0
`define LFS_OUT_CARRIER    2'h1

// frame layout
`define LFS_FRAME_BITS     16
`define LFS_DUMMY_BITS     7
`define LFS_CMD_HI         15
`define LFS_CMD_LO         13
`define LFS_ADR_HI         12
`define LFS_ADR_LO         9

// command codes
`define LFS_CMD_CLAMP_ON   3'h0
`define LFS_CMD_CLAMP_OFF  3'h1
`define LFS_CMD_SLEEP      3'h2
`define LFS_CMD_AGC_ON     3'h3
`define LFS_CMD_AGC_OFF    3'h4
`define LFS_CMD_SOFT_RST   3'h5
`define LFS_CMD_READ       3'h6
`define LFS_CMD_WRITE      3'h7

`endif

// ==== lfs_pkg.sv ====
// types shared by the serial configuration port files
package lfs_pkg;

	typedef enum logic [1:0] {
		mode_standby,
		mode_active,
		mode_sleep
	} lfs_mode_type;

	typedef enum logic {
		fetch_idle,
		fetch_wait
	} lfs_fetch_type;

	// state of the serial clock domain
	typedef struct packed {
		logic [15:0] shift;
		logic [7:0]  cnt;
	} lfs_link_type;

	// state of the system clock domain
	typedef struct packed {
		logic          cs_m;
		logic          cs_s;
		logic          cs_d;
		logic          sck_m;
		logic          sck_s;
		logic          sck_d;
		logic [7:0]    cnt_start;
		logic [4:0]    fall_cnt;
		logic          rd_armed;
		lfs_fetch_type fetch;
		logic [3:0]    fetch_addr;
		logic [15:0]   resp;
		logic [1:0]    outsel;
		logic          pulldown_bit;
		logic [2:0]    chan_dis;
		logic          alarm_ind;
		lfs_mode_type  mode;
		logic          clamp;
		logic          agc_pres;
		logic          soft_rst;
		logic [2:0]    scan_idx;
		logic          row_err;
		logic [7:0]    col_acc;
		logic          parity_err;
		logic          sdio_out;
		logic          sdio_oe_n;
		logic          alert_out;
		logic          alert_oe_n;
		logic          rssi_en;
		logic [1:0]    rssi_ch;
		logic          rssi_valid;
		logic          timers_en;
		logic          pulldown_en;
	} lfs_core_type;

endpackage : lfs_pkg

// ==== lfs_regfile.sv ====
// configuration register memory with registered read data
`timescale 1ns/1ps
`include "lfs_params.svh"

module lfs_regfile #(
	parameter int DEPTH = `LFS_REG_DEPTH,
	parameter int W     = `LFS_REG_W
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic         wr_en,
	input  wire logic [3:0]   wr_addr,
	input  wire logic [W-1:0] wr_data,
	input  wire logic [3:0]   rd_addr,
	output logic      [W-1:0] rd_data
);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [W-1:0]            rd;
	} lfs_mem_type;

	lfs_mem_type q;
	lfs_mem_type d;

	// the four address bits must reach every word
	if (DEPTH < 1 || DEPTH > 16 || W < 1) begin : g_check
		$error("lfs_regfile: DEPTH must be 1..16 and W at least 1");
	end

	// write port and registered read, out of range reads give zero
	always_comb begin
		d = q;
		if (wr_en && 32'(wr_addr) < DEPTH) begin
			d.mem[wr_addr] = wr_data;
		end
		if (32'(rd_addr) < DEPTH) begin
			d.rd = q.mem[rd_addr];
		end else begin
			d.rd = '0;
		end
	end

	// power-on clears every word, which leaves them all with bad parity
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rd_data = q.rd;

endmodule : lfs_regfile

// ==== lfs_config_port_properties.sv ====
// port assertions for the serial configuration port
`timescale 1ns/1ps
module lfs_config_port_properties (
	input wire logic                  clk,
	input wire logic                  reset_n,
	input wire logic                  cs_n,
	input wire logic                  sdio_oe_n,
	input wire logic                  alert_out,
	input wire logic                  alert_oe_n,
	input wire lfs_pkg::lfs_mode_type frontend_mode,
	input wire logic                  clamp_on,
	input wire logic                  soft_reset_pulse,
	input wire logic                  timers_enable,
	input wire logic                  rssi_enable,
	input wire logic [1:0]            rssi_channel,
	input wire logic                  rssi_valid,
	input wire logic                  discharge_pulldown_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// select low long enough to clear the two-flop sync
	sequence s_sel_low;
		(!cs_n) [*4];
	endsequence
	sequence s_strength_idle;
		(rssi_valid && cs_n) [*8];
	endsequence
	property p_timers_off;
		rssi_valid |-> !timers_enable;
	endproperty
	property p_forced_active;
		rssi_valid [*3] |-> frontend_mode == lfs_pkg::mode_active;
	endproperty
	property p_suspend;
		s_sel_low |-> !rssi_enable;
	endproperty
	property p_resume;
		s_strength_idle |-> rssi_enable;
	endproperty
	property p_channel;
		rssi_valid |-> rssi_channel != 2'h3;
	endproperty
	property p_pulldown;
		discharge_pulldown_enable |-> !timers_enable;
	endproperty
	property p_alert_sel;
		s_sel_low |-> alert_oe_n && !alert_out;
	endproperty
	property p_pin_free;
		rssi_enable |-> sdio_oe_n;
	endproperty
	property p_soft_pulse;
		soft_reset_pulse |=> !soft_reset_pulse && $stable(clamp_on);
	endproperty
	property p_soft_active;
		soft_reset_pulse |-> $past(frontend_mode) == lfs_pkg::mode_active;
	endproperty
	a_timers_off: assert property (p_timers_off) else $error("timers run in strength mode");
	a_forced_active: assert property (p_forced_active) else $error("not active");
	a_suspend: assert property (p_suspend) else $error("strength live in frame");
	a_resume: assert property (p_resume) else $error("strength not resumed");
	a_channel: assert property (p_channel) else $error("bad channel index");
	a_pulldown: assert property (p_pulldown) else $error("pulldown outside mode");
	a_alert_sel: assert property (p_alert_sel) else $error("fault pulled in frame");
	a_pin_free: assert property (p_pin_free) else $error("data pin driven");
	a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset pulse bad");
	a_soft_active: assert property (p_soft_active) else $error("soft reset idle");
endmodule : lfs_config_port_properties

bind lfs_config_port lfs_config_port_properties u_props (.clk, .reset_n, .cs_n, .sdio_oe_n,
	.alert_out, .alert_oe_n, .frontend_mode, .clamp_on, .soft_reset_pulse, .timers_enable,
	.rssi_enable, .rssi_channel, .rssi_valid, .discharge_pulldown_enable);

// ==== lfs_host_model.sv ====
// serial host: drives select, the shared clock pin and the data pin
`timescale 1ns/1ps
module lfs_host_model (
	output logic      cs_n,
	output logic      serial_clk,
	output logic      sdio_in,
	input  wire logic sdio_out,
	input  wire logic sdio_oe_n,
	input  wire logic alert_oe_n
);
	logic sclk;
	logic ck_en;
	logic hd;
	logic hd_en;
	// clock pin pulled up unless a party holds it low
	assign serial_clk = ck_en ? sclk : alert_oe_n;
	// a released data pin shows the inverse of its last value
	assign sdio_in = !sdio_oe_n ? sdio_out : (hd_en ? hd : ~hd);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		ck_en = 1'b0;
		hd = 1'b0;
		hd_en = 1'b0;
	end
	// n clocks, data set before each rise, sampled at the rise
	task automatic xfer(input logic [15:0] tx, input int n, input bit drv,
		output logic [15:0] rx);
		ck_en = 1'b1;
		#7 cs_n = 1'b0;
		hd_en = drv;
		for (int i = 0; i < n; i++) begin
			hd = tx[15 - (i % 16)];
			#32 sclk = 1'b1;
			rx = {rx[14:0], sdio_in};
			#32 sclk = 1'b0;
		end
		#32 hd_en = 1'b0;
		cs_n = 1'b1;
		#7 ck_en = 1'b0;
	endtask : xfer
endmodule : lfs_host_model

// ==== tb_top.sv ====
// self-checking bench for the serial configuration port
`timescale 1ns/1ps
`include "lfs_params.svh"
module tb_top;
	logic                  clk, reset_n, cs_n, serial_clk, sdio_in, sdio_out, sdio_oe_n;
	logic                  alert_out, alert_oe_n, demod_in, carrier_in, activity_in;
	logic                  alarm_in, agc_active_in, clamp_on, agc_preserve;
	logic                  soft_reset_pulse, timers_enable, rssi_enable, rssi_valid;
	logic                  discharge_pulldown_enable;
	logic [2:0]            wake_chan_in, active_chan_in;
	logic [1:0]            rssi_channel;
	logic [7:0]            strength_x, strength_y, strength_z;
	logic [7:0]            val [7];
	logic [15:0]           rx;
	lfs_pkg::lfs_mode_type frontend_mode;
	int                    failures, n_checks, pulses, cyc;

	lfs_config_port uut (.clk, .reset_n, .serial_clk, .cs_n, .sdio_in, .sdio_out, .sdio_oe_n,
		.alert_out, .alert_oe_n, .demod_in, .carrier_in, .activity_in, .alarm_in,
		.agc_active_in, .wake_chan_in, .active_chan_in, .strength_x, .strength_y,
		.strength_z, .frontend_mode, .clamp_on, .agc_preserve, .soft_reset_pulse,
		.timers_enable, .rssi_enable, .rssi_channel, .rssi_valid, .discharge_pulldown_enable);
	lfs_host_model host (.cs_n, .serial_clk, .sdio_in, .sdio_out, .sdio_oe_n, .alert_oe_n);

	always #4 clk = ~clk;
	// hang guard and soft reset pulse tally, sampled away from the launching edge
	always @(negedge clk) begin
		cyc++;
		if (soft_reset_pulse === 1'b1) pulses++;
		if (cyc == 20000) begin
			failures++;
			results();
		end
	end
	task automatic results;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : results
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// gap well above the select-high minimum, lets results settle
	task automatic frm(input logic [2:0] c, input logic [3:0] a, input logic [7:0] v);
		logic [15:0] r;
		host.xfer({c, a, v, ~^v}, 16, 1'b1, r);
		repeat (20) @(negedge clk);
	endtask : frm
	task automatic rd(input logic [3:0] a);
		frm(`LFS_CMD_READ, a, 8'h00);
		host.xfer(16'h0000, 16, 1'b0, rx);
		repeat (20) @(negedge clk);
	endtask : rd

	initial begin
		{clk, reset_n, demod_in, carrier_in, activity_in, alarm_in} = 6'h00;
		{agc_active_in, wake_chan_in, active_chan_in} = {1'b1, 3'h2, 3'h5};
		{strength_x, strength_y, strength_z} = {8'h10, 8'h50, 8'h30};
		val = '{8'h00, 8'h15, 8'h2A, 8'h3C, 8'hA5, 8'h5A, 8'h00};
		val[6] = ~(val[0] ^ val[1] ^ val[2] ^ val[3] ^ val[4] ^ val[5]);
		repeat (4) @(negedge clk);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		// cleared registers fail parity; idle pin copies demodulated data
		chk(alert_oe_n, 1'b0);
		for (int i = 0; i < 2; i++) begin
			demod_in = i[0];
			repeat (3) @(negedge clk);
			chk({sdio_oe_n, sdio_out}, {1'b0, i[0]});
		end
		$display("test reset done");
		foreach (val[i]) frm(`LFS_CMD_WRITE, i[3:0], val[i]);
		foreach (val[i]) begin
			rd(i[3:0]);
			chk(rx, {7'h00, val[i], ~^val[i]});
		end
		rd(4'h7);
		chk(rx, {7'h00, 3'h5, 1'b1, 3'h2, 1'b0, 1'b0});
		chk(alert_oe_n, 1'b1);
		frm(`LFS_CMD_WRITE, 4'h7, 8'hFF);
		rd(4'h7);
		chk(rx, {7'h00, 3'h5, 1'b1, 3'h2, 1'b0, 1'b0});
		$display("test registers done");
		for (int n = 15; n < 18; n += 2) begin
			host.xfer({`LFS_CMD_WRITE, 4'h1, 9'h1FE}, n, 1'b1, rx);
			repeat (20) @(negedge clk);
			rd(4'h1);
			chk(rx, {7'h00, val[1], ~^val[1]});
		end
		$display("test abort done");
		frm(`LFS_CMD_CLAMP_ON, 4'h0, 8'h00);
		chk(clamp_on, 1'b1);
		frm(`LFS_CMD_AGC_ON, 4'h0, 8'h00);
		chk(agc_preserve, 1'b1);
		activity_in = 1'b1;
		frm(`LFS_CMD_SOFT_RST, 4'h0, 8'h00);
		chk({pulses[3:0], clamp_on}, {4'h1, 1'b1});
		activity_in = 1'b0;
		frm(`LFS_CMD_SOFT_RST, 4'h0, 8'h00);
		chk(pulses[3:0], 4'h1);
		frm(`LFS_CMD_AGC_OFF, 4'h0, 8'h00);
		chk(agc_preserve, 1'b0);
		frm(`LFS_CMD_SLEEP, 4'h0, 8'h00);
		chk(frontend_mode, lfs_pkg::mode_sleep);
		frm(`LFS_CMD_CLAMP_OFF, 4'h0, 8'h00);
		chk({frontend_mode, clamp_on}, {lfs_pkg::mode_standby, 1'b0});
		$display("test commands done");
		frm(`LFS_CMD_WRITE, 4'h2, 8'h80);
		chk(discharge_pulldown_enable, 1'b0);
		frm(`LFS_CMD_WRITE, 4'h1, 8'h80);
		chk({rssi_enable, rssi_valid, rssi_channel, timers_enable}, 5'b11010);
		chk({discharge_pulldown_enable, sdio_oe_n}, 2'b11);
		chk(frontend_mode, lfs_pkg::mode_active);
		strength_z = 8'h70;
		repeat (4) @(negedge clk);
		chk(rssi_channel, 2'h2);
		frm(`LFS_CMD_WRITE, 4'h0, 8'h07);
		chk(rssi_valid, 1'b0);
		frm(`LFS_CMD_WRITE, 4'h0, 8'h00);
		chk(rssi_enable, 1'b1);
		frm(`LFS_CMD_WRITE, 4'h1, 8'hC0);
		chk(rssi_enable, 1'b1);
		frm(`LFS_CMD_WRITE, 4'h1, 8'h40);
		chk({discharge_pulldown_enable, timers_enable}, 2'b01);
		for (int i = 0; i < 2; i++) begin
			carrier_in = i[0];
			repeat (3) @(negedge clk);
			chk({sdio_oe_n, sdio_out}, {1'b0, i[0]});
		end
		$display("test strength done");
		results();
	end
endmodule : tb_top
